// ==== design/upop_exec.sv ====
// User-stack pop executor: runs the decrementing and incrementing pop forms
// Operation
// (RQ1) The source operand names a general register holding a user stack pointer that selects the popped byte.
// (RQ2) The incrementing pop copies the byte at the pointed-to register into the destination.
// (RQ3) After that write the incrementing pop adds one to the pointer and writes it back.
// (RQ4) The decrementing pop copies the pointed-to byte first, then subtracts one from the pointer.
// (RQ5) Both forms work inside the register file and never touch the system stack pointer.
// (RQ6) No condition flag changes during either pop.
// (RQ7) Opcode 92h is the decrementing pop, 93h the incrementing pop, three bytes each, eight cycles each.
`timescale 1ns/1ps
`include "upop_consts.svh"
module upop_exec import upop_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] src_reg,
	input wire logic [7:0] dst_reg,
	input wire logic [7:0] rf_rdata,
	output logic [7:0] rf_addr,
	output logic [7:0] rf_wdata,
	output logic rf_we,
	output logic rf_re,
	output logic busy,
	output logic done,
	output logic illegal
);
	upop_rf_if rf_bus ();
	upop_state_t state, next_state;
	logic [7:0] ptr, next_ptr;
	logic [7:0] data, next_data;
	logic [7:0] src, next_src;
	logic [7:0] dst, next_dst;
	logic incr, next_incr;
	logic [3:0] cyc, next_cyc;
	logic next_busy, next_done, next_illegal;

	// Read data from the core arrives with the registered strobe, one cycle after the sequencer raises it,
	// so each read state waits on a pending flag
	logic rd_wait, next_rd_wait;

	// Sequencer next-state logic
	always_comb begin
		next_state = state;
		next_ptr = ptr;
		next_data = data;
		next_src = src;
		next_dst = dst;
		next_incr = incr;
		next_cyc = cyc;
		next_rd_wait = 1'b0;
		next_busy = busy;
		next_done = 1'b0;
		next_illegal = 1'b0;
		rf_bus.addr = 8'h00;
		rf_bus.wdata = 8'h00;
		rf_bus.we = 1'b0;
		rf_bus.re = 1'b0;
		if (state != UPOP_IDLE) begin
			next_cyc = cyc + 4'h1;
		end
		case (state)
			UPOP_IDLE: begin
				next_cyc = 4'h0;
				if (start) begin
					if (opcode == `UPOP_OPC_DEC || opcode == `UPOP_OPC_INC) begin // [RQ7]
						next_incr = (opcode == `UPOP_OPC_INC);
						next_src = src_reg;
						next_dst = dst_reg;
						next_busy = 1'b1;
						next_cyc = 4'h1;
						next_state = UPOP_RD_PTR;
					end else begin
						next_illegal = 1'b1; // Other opcodes belong to other units
					end
				end
			end
			UPOP_RD_PTR: begin
				// Pointer lives in a general register, never the system SP [RQ1] [RQ5]
				rf_bus.addr = src;
				rf_bus.re = !rd_wait;
				next_rd_wait = 1'b1;
				if (rd_wait && cyc == `UPOP_PTR_READY) begin
					next_ptr = rf_rdata;
					next_rd_wait = 1'b0;
					next_state = UPOP_RD_DATA;
				end
			end
			UPOP_RD_DATA: begin
				rf_bus.addr = ptr; // [RQ1]
				rf_bus.re = !rd_wait;
				next_rd_wait = 1'b1;
				if (rd_wait && cyc == `UPOP_DATA_READY) begin
					next_data = rf_rdata;
					next_rd_wait = 1'b0;
					next_state = UPOP_WR_DST;
				end
			end
			UPOP_WR_DST: begin
				// Destination written before the pointer moves [RQ2] [RQ4]
				rf_bus.addr = dst;
				rf_bus.wdata = data;
				rf_bus.we = 1'b1;
				next_state = UPOP_WR_PTR;
			end
			UPOP_WR_PTR: begin
				// Wraps modulo 256 within the register file [RQ3] [RQ4]
				rf_bus.addr = src;
				rf_bus.wdata = incr ? ptr + `UPOP_STEP_ONE : ptr - `UPOP_STEP_ONE;
				rf_bus.we = 1'b1;
				next_state = UPOP_FINISH;
			end
			UPOP_FINISH: begin
				// Entered with the count already at eight, so done lands on the eighth edge [RQ7]
				if (cyc == `UPOP_INSTR_CYCLES) begin
					next_busy = 1'b0;
					next_done = 1'b1;
					next_state = UPOP_IDLE;
				end
			end
			default: begin
				next_state = UPOP_IDLE;
				next_busy = 1'b0;
			end
		endcase
	end

	// No flag port exists at all, so flags cannot be disturbed [RQ6]
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= UPOP_IDLE;
			ptr <= 8'h00;
			data <= 8'h00;
			src <= 8'h00;
			dst <= 8'h00;
			incr <= 1'b0;
			cyc <= 4'h0;
			rd_wait <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			illegal <= 1'b0;
		end else begin
			state <= next_state;
			ptr <= next_ptr;
			data <= next_data;
			src <= next_src;
			dst <= next_dst;
			incr <= next_incr;
			cyc <= next_cyc;
			rd_wait <= next_rd_wait;
			busy <= next_busy;
			done <= next_done;
			illegal <= next_illegal;
		end
	end

	upop_rf_port u_port (
		.clk(clk),
		.reset_n(reset_n),
		.rf(rf_bus),
		.rf_addr(rf_addr),
		.rf_wdata(rf_wdata),
		.rf_we(rf_we),
		.rf_re(rf_re)
	);

	// Done is registered on the eighth edge after the take, so it is sampled high one edge later
	a_done_eight: assert property (@(posedge clk) disable iff (!reset_n) // [RQ7]
		(start && !busy && (opcode == `UPOP_OPC_DEC || opcode == `UPOP_OPC_INC)) |-> ##9 done)
		else $error("pop did not finish in eight cycles");
	a_ptr_step: assert property (@(posedge clk) disable iff (!reset_n) // [RQ3]
		(rf_we && $past(state) == UPOP_WR_PTR) |->
		rf_wdata == ($past(incr, 2) ? $past(ptr, 2) + 8'h01 : $past(ptr, 2) - 8'h01))
		else $error("pointer write-back has wrong value");
	a_dst_first: assert property (@(posedge clk) disable iff (!reset_n) // [RQ4]
		(state == UPOP_WR_DST) |=> (rf_we && rf_addr == $past(dst)) ##1 (rf_we && rf_addr == $past(src, 2)))
		else $error("destination not written before pointer");
	a_dst_data: assert property (@(posedge clk) disable iff (!reset_n) // [RQ2]
		(state == UPOP_WR_DST) |=> (rf_we && rf_wdata == $past(data)))
		else $error("popped byte not written to destination");
	a_ptr_addr: assert property (@(posedge clk) disable iff (!reset_n) // [RQ1]
		(state == UPOP_RD_DATA && !rd_wait) |=> (rf_re && rf_addr == $past(ptr)))
		else $error("data read not at pointer");
	a_ptr_reg: assert property (@(posedge clk) disable iff (!reset_n) // [RQ5]
		(state == UPOP_WR_PTR) |=> (rf_addr == $past(src)))
		else $error("pointer written outside source register");
	a_write_count: assert property (@(posedge clk) disable iff (!reset_n) // [RQ6]
		(state == UPOP_IDLE) |=> !rf_we)
		else $error("write issued while idle");
	a_illegal_op: assert property (@(posedge clk) disable iff (!reset_n) // [RQ7]
		(start && !busy && opcode != `UPOP_OPC_DEC && opcode != `UPOP_OPC_INC) |=> (illegal && !busy))
		else $error("unknown opcode not flagged");
endmodule

// ==== shared/upop_consts.svh ====
// Constants for the user-stack pop executor
`ifndef UPOP_CONSTS_SVH
`define UPOP_CONSTS_SVH
`define UPOP_OPC_DEC 8'h92
`define UPOP_OPC_INC 8'h93
`define UPOP_INSTR_CYCLES 4'h8
`define UPOP_PTR_READY 4'h3
`define UPOP_DATA_READY 4'h5
`define UPOP_STEP_ONE 8'h01
`endif

// ==== shared/upop_pkg.sv ====
// Types for the user-stack pop executor
package upop_pkg;
	typedef enum logic [2:0] {
		UPOP_IDLE,
		UPOP_RD_PTR,
		UPOP_RD_DATA,
		UPOP_WR_DST,
		UPOP_WR_PTR,
		UPOP_FINISH
	} upop_state_t;
endpackage

// ==== shared/upop_rf_if.sv ====
// Register-file access bundle between the sequencer and its port stage
`timescale 1ns/1ps
interface upop_rf_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic we;
	logic re;
	modport seq (output addr, output wdata, output we, output re);
	modport port (input addr, input wdata, input we, input re);
endinterface

// ==== design/upop_rf_port.sv ====
// Output register stage for register-file access
`timescale 1ns/1ps
module upop_rf_port (
	input wire logic clk,
	input wire logic reset_n,
	upop_rf_if.port rf,
	output logic [7:0] rf_addr,
	output logic [7:0] rf_wdata,
	output logic rf_we,
	output logic rf_re
);
	// Registered so the core sees clean, glitch-free strobes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rf_addr <= 8'h00;
			rf_wdata <= 8'h00;
			rf_we <= 1'b0;
			rf_re <= 1'b0;
		end else begin
			rf_addr <= rf.addr;
			rf_wdata <= rf.wdata;
			rf_we <= rf.we;
			rf_re <= rf.re;
		end
	end
endmodule

// ==== tb/upop_rf_model.sv ====
// Register-file partner model for the user-stack pop executor
`timescale 1ns/1ps
module upop_rf_model (
	input wire logic clk,
	input wire logic [7:0] rf_addr,
	input wire logic [7:0] rf_wdata,
	input wire logic rf_we,
	input wire logic rf_re,
	output logic [7:0] rf_rdata
);
	logic [7:0] mem [256];
	logic [7:0] rd_addr;
	logic rd_seen = 1'b0;
	// Data while strobed or while the last strobed address still stands; inverted
	// otherwise, so a capture from an address never strobed shows up
	assign rf_rdata = (rf_re || (rd_seen && rf_addr == rd_addr)) ? mem[rf_addr] : ~mem[rf_addr];
	// Byte writes from the executor, and the address of the last strobed read
	always @(posedge clk) begin
		if (rf_we) begin
			mem[rf_addr] <= rf_wdata;
		end
		if (rf_re) begin
			rd_addr <= rf_addr;
			rd_seen <= 1'b1;
		end
	end
endmodule

// ==== tb/user_stack_pop_exec_tb.sv ====
// Self-checking bench for the user-stack pop executor
`timescale 1ns/1ps
module user_stack_pop_exec_tb;
	logic clk = 0;
	logic reset_n = 0;
	logic start = 0;
	logic [7:0] opcode = 8'h00;
	logic [7:0] src_reg = 8'h00;
	logic [7:0] dst_reg = 8'h00;
	logic [7:0] rf_rdata, rf_addr, rf_wdata;
	logic rf_we, rf_re, busy, done, illegal;
	int error_cnt = 0;
	int n_tests = 0;
	// 50 MHz clock
	always #10 clk = ~clk;
	upop_exec dut (.clk(clk), .reset_n(reset_n), .start(start), .opcode(opcode), .src_reg(src_reg),
		.dst_reg(dst_reg), .rf_rdata(rf_rdata), .rf_addr(rf_addr), .rf_wdata(rf_wdata),
		.rf_we(rf_we), .rf_re(rf_re), .busy(busy), .done(done), .illegal(illegal));
	upop_rf_model rf (.clk(clk), .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_we(rf_we),
		.rf_re(rf_re), .rf_rdata(rf_rdata));
	// Compare and count
	task check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One pop: busy for 7 edges, done on the 8th, then file contents judged
	task run(input logic [7:0] op, input logic [7:0] s, input logic [7:0] d, input logic [7:0] ptr,
		input logic [7:0] val, input logic [7:0] nptr);
		rf.mem[s] = ptr;
		rf.mem[ptr] = val;
		@(posedge clk);
		start <= 1'b1;
		opcode <= op;
		src_reg <= s;
		dst_reg <= d;
		@(posedge clk);
		start <= 1'b0;
		repeat (7) begin
			@(posedge clk);
			#1 check({6'h00, busy, done}, 8'h02, "busy phase");
		end
		@(posedge clk);
		#1 check({6'h00, busy, done}, 8'h01, "done at cycle 8");
		check(rf.mem[d], val, "destination");
		check(rf.mem[s], nptr, "pointer");
		check(rf.mem[ptr], val, "stack byte kept");
	endtask
	task test_dec();
		run(8'h92, 8'h00, 8'h02, 8'h42, 8'h6F, 8'h41);
		$display("test decrementing pop finished");
	endtask
	task test_inc();
		run(8'h93, 8'h00, 8'h02, 8'h01, 8'h70, 8'h02);
		$display("test incrementing pop finished");
	endtask
	// Pointer wraps both ways, the two pops one idle edge apart
	task test_wrap();
		run(8'h93, 8'h10, 8'h20, 8'hFF, 8'h5A, 8'h00);
		run(8'h92, 8'h10, 8'h21, 8'h00, 8'hC3, 8'hFF);
		$display("test pointer wrap finished");
	endtask
	// A non-pop opcode must flag and write nothing
	task test_illegal();
		rf.mem[8'h30] = 8'h11;
		@(posedge clk);
		start <= 1'b1;
		opcode <= 8'h50;
		dst_reg <= 8'h30;
		@(posedge clk);
		start <= 1'b0;
		#1 check({6'h00, busy, illegal}, 8'h01, "illegal pulse");
		repeat (8) @(posedge clk);
		check(rf.mem[8'h30], 8'h11, "untouched");
		$display("test illegal opcode finished");
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#40000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		#1 check({5'h00, busy, done, rf_we}, 8'h00, "reset outputs");
		test_dec();
		test_inc();
		test_wrap();
		test_illegal();
		print_verdict();
	end
endmodule
